// ===== design/reconfig_pkg.sv
// Purpose: Shared constants for the partial reconfiguration handshake
// Assumes: Single 20 MHz clock, all pins synchronous to it
// Notes: Mode and state encodings used by the device-side controller
`default_nettype none
package reconfig_pkg;
   localparam int CLK_HZ = 20_000_000;
   // Settle time after request before ready is released
   localparam int READY_DELAY_NS = 200;
   localparam int READY_DELAY_CYCLES =
      (READY_DELAY_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
   localparam int DATA_WIDTH = 16;
   localparam logic [1:0] SCHEME_FAST_PARALLEL_X16 = 2'h3;
   localparam logic MODE_EXTERNAL_HOST = 1'b1;
   localparam int WORD_COUNT_WIDTH = 16;
   typedef enum logic [2:0] {
      ST_IDLE,
      ST_PREPARE,
      ST_LOAD,
      ST_DONE,
      ST_FAULT
   } session_state_t;
endpackage : reconfig_pkg
`default_nettype wire

// ===== design/status_pin_driver.sv
// Purpose: Drives one status pin low or releases it
// Assumes: Pin may be push-pull or open-drain with external pull-up
// Notes: Released means high when push-pull, undriven when open-drain
`default_nettype none
module status_pin_driver (
   input wire logic clk,
   input wire logic resetn,
   input wire logic open_drain,
   input wire logic release_pin,
   output logic pin_out,
   output logic pin_oe
);
   logic released;

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         released <= 1'b0;
      end else begin
         released <= release_pin;
      end
   end

   // Open-drain only ever pulls low; the pull-up supplies the high
   assign pin_out = open_drain ? 1'b0 : released;
   assign pin_oe = open_drain ? ~released : 1'b1;
endmodule : status_pin_driver
`default_nettype wire

// ===== design/partial_reconfig_handshake.sv
// Purpose: Device side of the partial reconfiguration pin handshake
// Assumes: Host drives request and 16-bit data synchronous to clk
// Notes: Status pins are driven low and released as sessions progress
// Function
// [R1] Host raises request to start session
// [R2] Host lowers request to end session
// [R3] Request honoured only in host x16 mode
// [R4] Ready held low until able, then released
// [R5] Error kept low while no error seen
// [R6] Error released high once error detected
// [R7] Complete held low until finished, then released
// [R8] Host waits ready, drops request after outcome
`default_nettype none
module partial_reconfig_handshake
   import reconfig_pkg::*;
#(
   parameter int DATA_W = DATA_WIDTH,
   parameter int COUNT_W = WORD_COUNT_WIDTH
) (
   input wire logic clk,
   input wire logic resetn,
   input wire logic external_host_mode,
   input wire logic [1:0] fast_parallel_load_scheme,
   input wire logic open_drain,
   input wire logic [COUNT_W-1:0] expected_words,
   input wire logic reconfig_request,
   input wire logic data_valid,
   input wire logic [DATA_W-1:0] data_word,
   input wire logic data_check_fail,
   output logic reconfig_ready_flag,
   output logic reconfig_ready_flag_oe,
   output logic reconfig_fault_flag,
   output logic reconfig_fault_flag_oe,
   output logic reconfig_complete_flag,
   output logic reconfig_complete_flag_oe,
   output logic load_strobe,
   output logic [DATA_W-1:0] load_data,
   output logic session_active
);

   ////////////////////////////////////////////////////////////////////////////
   // Qualification and decode

   session_state_t state;
   session_state_t next_state;
   logic [7:0] settle_count;
   logic [7:0] next_settle_count;
   logic [COUNT_W-1:0] word_count;
   logic [COUNT_W-1:0] next_word_count;
   logic mode_ok;
   logic request_ok;
   logic abort;
   logic settled;
   logic last_word;
   logic word_taken;
   logic word_bad;
   logic word_good;
   logic load_finished;
   logic in_idle;
   logic in_prepare;
   logic in_load;
   logic in_done;
   logic in_fault;

   // Named state decodes keep the counters and the pin logic readable
   assign in_idle = (state == ST_IDLE);
   assign in_prepare = (state == ST_PREPARE);
   assign in_load = (state == ST_LOAD);
   assign in_done = (state == ST_DONE);
   assign in_fault = (state == ST_FAULT);

   // Wrong mode or scheme makes the pin a plain don't-care
   assign mode_ok = (external_host_mode == MODE_EXTERNAL_HOST)
      && (fast_parallel_load_scheme == SCHEME_FAST_PARALLEL_X16); // [R3]
   assign request_ok = reconfig_request && mode_ok; // [R3]
   // Losing the mode mid-session counts as a withdrawn request
   assign abort = !request_ok; // [R2] [R3]
   // Ends one short since the count starts at zero; the ready pin register then adds one more edge
   assign settled = (settle_count == 8'(READY_DELAY_CYCLES - 1));
   assign word_taken = in_load && data_valid && request_ok; // [R8]
   assign word_bad = word_taken && data_check_fail;
   assign word_good = word_taken && !data_check_fail;
   assign last_word = (word_count == expected_words - COUNT_W'(1));
   assign load_finished = word_good && last_word; // [R7]

   ////////////////////////////////////////////////////////////////////////////
   // Session sequencing

   always_comb begin
      next_state = state;
      case (state)
         ST_IDLE: begin
            if (request_ok) begin // [R1]
               next_state = ST_PREPARE;
            end
         end
         ST_PREPARE: begin
            if (abort) begin // [R2]
               next_state = ST_IDLE;
            end else if (settled) begin
               next_state = ST_LOAD; // [R4]
            end
         end
         ST_LOAD: begin
            if (abort) begin // [R2]
               next_state = ST_IDLE;
            end else if (word_bad) begin
               next_state = ST_FAULT; // [R6]
            end else if (load_finished) begin
               next_state = ST_DONE; // [R7]
            end
         end
         ST_DONE, ST_FAULT: begin
            // Outcome holds until the host withdraws its request
            if (abort) begin // [R8]
               next_state = ST_IDLE;
            end
         end
         default: begin
            next_state = ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         state <= ST_IDLE;
      end else begin
         state <= next_state;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Counters

   // Eight bits leave headroom should the settle time be raised
   assign next_settle_count = in_prepare ? (settle_count + 8'h01) : 8'h00;
   // Count restarts whenever the session leaves the loading phase
   assign next_word_count = !in_load ? '0
      : (word_taken ? (word_count + COUNT_W'(1)) : word_count);

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         settle_count <= 8'h00;
      end else begin
         settle_count <= next_settle_count;
      end
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         word_count <= '0;
      end else begin
         word_count <= next_word_count;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Data forwarding

   // Strobe marks only words that passed the check
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         load_strobe <= 1'b0;
      end else begin
         load_strobe <= word_good;
      end
   end

   // Bad words are captured too, so the refused word stays visible
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         load_data <= '0;
      end else if (word_taken) begin
         load_data <= data_word;
      end
   end

   assign session_active = !in_idle;

   ////////////////////////////////////////////////////////////////////////////
   // Status pins

   logic release_ready;
   logic release_fault;
   logic release_complete;

   // Ready is released only while loading, so it is driven low again once an outcome is reached
   assign release_ready = in_load; // [R4]
   assign release_fault = in_fault; // [R5] [R6]
   assign release_complete = in_done; // [R7]

   // One driver per pin keeps the open-drain choice in one place
   status_pin_driver ready_pin (
      .clk(clk),
      .resetn(resetn),
      .open_drain(open_drain),
      .release_pin(release_ready),
      .pin_out(reconfig_ready_flag),
      .pin_oe(reconfig_ready_flag_oe)
   );

   status_pin_driver fault_pin (
      .clk(clk),
      .resetn(resetn),
      .open_drain(open_drain),
      .release_pin(release_fault),
      .pin_out(reconfig_fault_flag),
      .pin_oe(reconfig_fault_flag_oe)
   );

   status_pin_driver complete_pin (
      .clk(clk),
      .resetn(resetn),
      .open_drain(open_drain),
      .release_pin(release_complete),
      .pin_out(reconfig_complete_flag),
      .pin_oe(reconfig_complete_flag_oe)
   );

endmodule : partial_reconfig_handshake
`default_nettype wire

// ===== bench/reconfig_host.sv
// Purpose: Host model that runs reconfig sessions
// Assumes: Pin levels arrive already resolved
// Notes: Drives on the falling edge
`default_nettype none
module reconfig_host (
   input wire logic clk,
   input wire logic rdy,
   input wire logic flt,
   input wire logic cpl,
   output logic req = 1'b0,
   output logic dv = 1'b0,
   output logic [15:0] dw = 16'h0000,
   output logic bad = 1'b0
);
   timeunit 1ns;
   timeprecision 1ns;
   task automatic run(input int n, input int bad_at);
      int t;
      @(negedge clk);
      req = 1'b1;
      for (t = 0; t < 40 && !rdy; t++) @(negedge clk);
      for (int i = 0; i < n && rdy; i++) begin
         dv = 1'b1;
         dw = 16'h1230 + 16'(i);
         bad = (i == bad_at);
         @(negedge clk);
      end
      dv = 1'b0;
      // Inverted so stale data never looks held
      dw = ~dw;
      bad = 1'b0;
      for (t = 0; t < 20 && !(cpl || flt); t++) @(negedge clk);
      req = 1'b0;
   endtask : run
endmodule : reconfig_host
`default_nettype wire

// ===== bench/reconfig_chk.sv
// Purpose: Handshake checker
// Assumes: Undriven pin reads high
// Notes: Bound to the top
`default_nettype none
module reconfig_chk (
   input wire logic clk,
   input wire logic resetn,
   input wire logic external_host_mode,
   input wire logic [1:0] fast_parallel_load_scheme,
   input wire logic data_valid,
   input wire logic data_check_fail,
   input wire logic reconfig_ready_flag,
   input wire logic reconfig_ready_flag_oe,
   input wire logic reconfig_fault_flag,
   input wire logic reconfig_fault_flag_oe,
   input wire logic reconfig_complete_flag,
   input wire logic reconfig_complete_flag_oe,
   input wire logic reconfig_request,
   input wire logic load_strobe,
   input wire logic session_active
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking @(posedge clk); endclocking
   default disable iff (!resetn);
   wire rdy = reconfig_ready_flag_oe ? reconfig_ready_flag : 1'b1;
   wire flt = reconfig_fault_flag_oe ? reconfig_fault_flag : 1'b1;
   wire cpl = reconfig_complete_flag_oe ? reconfig_complete_flag : 1'b1;
   wire bad = data_valid && data_check_fail;
   wire ok = external_host_mode && fast_parallel_load_scheme == 2'h3;
   mode_gate_a: assert property (!session_active && !ok |=> !session_active)
      else $error("bad mode");
   ready_wait_a: assert property ($rose(session_active) |->
      !rdy [*5] ##1 (rdy || !session_active)) else $error("ready");
   fault_quiet_a: assert property (session_active && !flt |=>
      !flt || $past(bad, 2)) else $error("fault");
   fault_set_a: assert property (rdy && bad ##1 reconfig_request |=> flt)
      else $error("no fault");
   done_set_a: assert property ($rose(cpl) |-> $past(load_strobe) && !flt)
      else $error("done");
endmodule : reconfig_chk
bind partial_reconfig_handshake reconfig_chk chk_u (.clk, .resetn, .external_host_mode,
   .fast_parallel_load_scheme, .data_valid, .data_check_fail, .reconfig_ready_flag,
   .reconfig_ready_flag_oe, .reconfig_fault_flag, .reconfig_fault_flag_oe,
   .reconfig_complete_flag, .reconfig_complete_flag_oe, .reconfig_request, .load_strobe,
   .session_active);
`default_nettype wire

// ===== bench/partial_reconfig_handshake_tb.sv
// Purpose: Bench for the handshake
// Assumes: Host model at far side
// Notes: Released pins read high
`default_nettype none
module partial_reconfig_handshake_tb;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk = 0;
   logic resetn = 0;
   logic mode = 1;
   logic [1:0] scheme = 2'h3;
   logic od = 0;
   logic [15:0] words = 16'h0003;
   logic req, dv, bad, r_o, r_e, f_o, f_e, c_o, c_e, ls, act;
   logic [15:0] dw, ld;
   wire rdy = r_e ? r_o : 1'b1;
   wire flt = f_e ? f_o : 1'b1;
   wire cpl = c_e ? c_o : 1'b1;
   int fail_count = 0;
   int checks = 0;
   int strobes = 0;
   always #25 clk = ~clk;
   always @(posedge clk) if (ls === 1'b1) strobes++;
   partial_reconfig_handshake dut_u (.clk, .resetn, .external_host_mode(mode),
      .fast_parallel_load_scheme(scheme), .open_drain(od), .expected_words(words),
      .reconfig_request(req), .data_valid(dv), .data_word(dw), .data_check_fail(bad),
      .reconfig_ready_flag(r_o), .reconfig_ready_flag_oe(r_e), .reconfig_fault_flag(f_o),
      .reconfig_fault_flag_oe(f_e), .reconfig_complete_flag(c_o),
      .reconfig_complete_flag_oe(c_e), .load_strobe(ls), .load_data(ld), .session_active(act));
   reconfig_host host_u (.clk, .rdy, .flt, .cpl, .req, .dv, .dw, .bad);
   ////////////////////////////////
   task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
      checks++;
      if (got !== exp) begin
         fail_count++;
         $display("[ERR] %0t got %h exp %h", $time, got, exp);
      end
   endtask : cmp
   task automatic summarize();
      $display("checks %0d fail_count %0d", checks, fail_count);
      if (fail_count == 0 && checks > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask : summarize
   task automatic good_load();
      strobes = 0;
      host_u.run(3, 9);
      cmp(16'(strobes), 16'h0003);
      cmp(16'({cpl, flt}), 16'h0002);
      cmp(ld, 16'h1232);
      cmp(16'(act), 16'h0001);
      repeat (3) @(negedge clk);
      cmp(16'({rdy, cpl}), 16'h0000);
      cmp(16'(act), 16'h0000);
   endtask : good_load
   task automatic bad_word();
      od = 1'b1;
      strobes = 0;
      host_u.run(3, 1);
      cmp(16'(strobes), 16'h0001);
      cmp(16'({cpl, flt}), 16'h0001);
      repeat (3) @(negedge clk);
      cmp(16'({cpl, flt}), 16'h0000);
   endtask : bad_word
   task automatic mode_gate();
      strobes = 0;
      mode = 1'b0;
      host_u.run(1, 9);
      mode = 1'b1;
      scheme = 2'h1;
      host_u.run(1, 9);
      cmp(16'(strobes), 16'h0000);
      cmp(16'({rdy, cpl}), 16'h0000);
      cmp(16'(act), 16'h0000);
   endtask : mode_gate
   initial begin
      repeat (6) @(negedge clk);
      resetn = 1'b1;
      good_load();
      bad_word();
      mode_gate();
      summarize();
   end
   initial begin
      #100000;
      fail_count++;
      summarize();
   end
endmodule : partial_reconfig_handshake_tb
`default_nettype wire
